/* File: design/oals_serializer.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module oals_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : oals_fifo

////////////////////////////////////////////////////////////////////////////////
module oals_serializer
	import oals_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Sample clock from the pin, asynchronous to ref_clk
	input wire logic sample_clock_input,
	// Conversion results, channel c in bits c*10 +: 10
	input wire logic conv_valid,
	output logic conv_ready,
	input wire logic [SET_BITS-1:0] conv_data,
	// Output format controls
	input wire logic twos_complement_select,
	input wire logic msb_first_select,
	// Serial outputs, differential pairs
	output logic [CH_COUNT-1:0] data_out_p,
	output logic [CH_COUNT-1:0] data_out_n,
	output logic bit_clock_out_p,
	output logic bit_clock_out_n,
	output logic frame_clock_pos,
	output logic frame_clock_neg
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic samp_s1_q;
	logic samp_s2_q;
	logic samp_s3_q;
	oals_state_t state_q;
	oals_state_t state_d;
	logic [4:0] tick_q;
	logic [4:0] tick_d;
	logic [SET_BITS-1:0] word_q;
	logic twos_q;
	logic msb_q;
	logic [CH_COUNT-1:0] lane_bit;
	logic [CH_COUNT-1:0] lane_lsb;
	logic [CH_COUNT-1:0] lane_msb;
	logic fifo_valid;
	logic [SET_BITS-1:0] fifo_data;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rst_sync_n = rst_s2_q;

	// Sample clock edge: the PLL equivalent restarts the bit phase each edge that finds a word in the FIFO
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			samp_s1_q <= 1'b0;
			samp_s2_q <= 1'b0;
			samp_s3_q <= 1'b0;
		end else begin
			samp_s1_q <= sample_clock_input;
			samp_s2_q <= samp_s1_q;
			samp_s3_q <= samp_s2_q;
		end
	end
	wire frame_edge = samp_s2_q && !samp_s3_q;
	wire load = frame_edge && fifo_valid;

	oals_fifo #(
		.WIDTH(SET_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_sync_n),
		.in_valid(conv_valid),
		.in_ready(conv_ready),
		.in_data(conv_data),
		.out_valid(fifo_valid),
		.out_ready(frame_edge),
		.out_data(fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	wire tick_end = tick_q == TICK_LAST;
	always_comb begin
		state_d = state_q;
		tick_d = tick_q;
		case (state_q)
			OALS_IDLE: begin
				if (load) begin
					state_d = OALS_RUN;
					tick_d = '0;
				end
			end
			OALS_RUN: begin
				if (load) begin
					tick_d = '0;
				end else if (tick_end) begin
					state_d = OALS_IDLE;
					tick_d = '0;
				end else begin
					tick_d = tick_q + 5'h01;
				end
			end
			default: begin
				state_d = OALS_IDLE;
				tick_d = '0;
			end
		endcase
	end

	// Mode is taken per frame so a change never splits a word
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q <= OALS_IDLE;
			tick_q <= '0;
			word_q <= '0;
			twos_q <= 1'b0;
			msb_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			if (load) begin
				word_q <= fifo_data;
				twos_q <= twos_complement_select;
				msb_q <= msb_first_select;
			end
		end
	end

	wire running = state_q == OALS_RUN;
	wire [3:0] bit_pos = tick_q[4:1];
	wire [3:0] sel = msb_q ? BIT_LAST - bit_pos : bit_pos;

	genvar c;
	generate
		for (c = 0; c < CH_COUNT; c++) begin : g_lane
			wire [RES_BITS-1:0] res = word_q[c*RES_BITS +: RES_BITS];
			wire [RES_BITS-1:0] coded = {res[RES_BITS-1] ^ twos_q,
				res[RES_BITS-2:0]};
			wire [WORD_BITS-1:0] word12 = {coded, {PAD_BITS{1'b0}}};
			assign lane_bit[c] = running && word12[sel];
			assign lane_lsb[c] = res[0];
			assign lane_msb[c] = res[RES_BITS-1];
		end
	endgenerate

	// Clocks leave through the same flops as data to keep edges aligned
	wire bclk_d = running && (tick_q[0] ^ tick_q[1]);
	wire fclk_d = running && (bit_pos < FRAME_HIGH_BITS);

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			data_out_p <= '0;
			data_out_n <= '1;
			bit_clock_out_p <= 1'b0;
			bit_clock_out_n <= 1'b1;
			frame_clock_pos <= 1'b0;
			frame_clock_neg <= 1'b1;
		end else begin
			data_out_p <= lane_bit;
			data_out_n <= ~lane_bit;
			bit_clock_out_p <= bclk_d;
			bit_clock_out_n <= ~bclk_d;
			frame_clock_pos <= fclk_d;
			frame_clock_neg <= ~fclk_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_pad_first;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(frame_clock_pos) && !msb_q |-> (data_out_p == '0) [*4];
	endproperty
	a_pad_first: assert property (p_pad_first)
		else $error("pad zeros not first");

	property p_lsb_third;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(frame_clock_pos) && !msb_q && !load |-> ##4 data_out_p == lane_lsb;
	endproperty
	a_lsb_third: assert property (p_lsb_third)
		else $error("LSB not after pads");

	property p_msb_lead;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(frame_clock_pos) && msb_q |->
			data_out_p == (lane_msb ^ {CH_COUNT{twos_q}});
	endproperty
	a_msb_lead: assert property (p_msb_lead)
		else $error("MSB bit wrong");

	// A new load restarts the word, so an attempt cut short by it is dropped
	property p_msb_tail;
		@(posedge ref_clk) disable iff (!rst_sync_n || load)
		$rose(frame_clock_pos) && msb_q |-> ##20 (data_out_p == '0) [*4];
	endproperty
	a_msb_tail: assert property (p_msb_tail)
		else $error("pads not last");

	property p_frame_len;
		@(posedge ref_clk) disable iff (!rst_sync_n || load)
		$rose(frame_clock_pos) |->
			frame_clock_pos [*8] ##1 frame_clock_pos [*4] ##1 !frame_clock_pos;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame width wrong");

	property p_bclk_mid;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(frame_clock_pos) |->
			!bit_clock_out_p ##1 bit_clock_out_p [*2] ##1 !bit_clock_out_p;
	endproperty
	a_bclk_mid: assert property (p_bclk_mid)
		else $error("bit clock phase");

	property p_pairs;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		(bit_clock_out_n == !bit_clock_out_p)
			&& (frame_clock_neg == !frame_clock_pos)
			&& (data_out_n == ~data_out_p);
	endproperty
	a_pairs: assert property (p_pairs)
		else $error("pair mismatch");

	property p_load_start;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		load |=> running && tick_q == '0 ##1 frame_clock_pos;
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("frame not started");

	property p_shift_step;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		running && !tick_end && !load |=> tick_q == $past(tick_q) + 5'h01;
	endproperty
	a_shift_step: assert property (p_shift_step)
		else $error("shift stalled");

	property p_straight;
		@(posedge ref_clk) disable iff (!rst_sync_n)
		$rose(frame_clock_pos) && msb_q && !twos_q |-> data_out_p == lane_msb;
	endproperty
	a_straight: assert property (p_straight)
		else $error("code altered");

	c_msb_frame: cover property (@(posedge ref_clk) $rose(frame_clock_pos) && msb_q);
	c_twos_frame: cover property (@(posedge ref_clk) $rose(frame_clock_pos) && twos_q);
	c_fifo_full: cover property (@(posedge ref_clk) !conv_ready);
	c_underrun: cover property (@(posedge ref_clk) frame_edge && !fifo_valid);
endmodule : oals_serializer

`default_nettype wire

/* File: design/oals_pkg.sv */
package oals_pkg;
	localparam int CH_COUNT = 8;
	localparam int RES_BITS = 10;
	localparam int PAD_BITS = 2;
	localparam int WORD_BITS = RES_BITS + PAD_BITS;
	localparam int SET_BITS = CH_COUNT * RES_BITS;
	localparam int FIFO_DEPTH = 8;
	// Two ticks per bit put each bit clock edge mid-bit
	localparam int TICKS_PER_BIT = 2;
	localparam int FRAME_TICKS = WORD_BITS * TICKS_PER_BIT;
	localparam logic [4:0] TICK_LAST = 5'(FRAME_TICKS - 1);
	localparam logic [3:0] BIT_LAST = 4'(WORD_BITS - 1);
	localparam logic [3:0] FRAME_HIGH_BITS = 4'(WORD_BITS / 2);
	localparam logic [3:0] PAD_BITS_W = 4'(PAD_BITS);

	typedef enum logic {
		OALS_IDLE = 1'b0,
		OALS_RUN = 1'b1
	} oals_state_t;
endpackage : oals_pkg

/* File: tb/oals_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module oals_rx_model
	import oals_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link from the serializer
	input wire logic [CH_COUNT-1:0] data_p,
	input wire logic [CH_COUNT-1:0] data_n,
	input wire logic bclk_p,
	input wire logic bclk_n,
	input wire logic fclk_p,
	input wire logic fclk_n,
	// Captured bits in arrival order, and link statistics
	output logic [WORD_BITS-1:0] rx_bits [CH_COUNT],
	output int n_frames,
	output int n_edges,
	output int n_fhigh,
	output logic pair_bad
);
	logic bclk_q;
	logic fclk_q;

	// Oversampled by the serializer's own clock, so a toggle of the bit
	// clock between two samples marks one capture point
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bclk_q <= 1'b0;
			fclk_q <= 1'b0;
			n_frames <= 0;
			n_edges <= 0;
			n_fhigh <= 0;
			pair_bad <= 1'b0;
		end else begin
			bclk_q <= bclk_p;
			fclk_q <= fclk_p;
			if (data_n !== ~data_p || bclk_n !== !bclk_p || fclk_n !== !fclk_p)
				pair_bad <= 1'b1;
			if (fclk_p && !fclk_q) begin
				n_edges <= 0;
				n_fhigh <= 1;
			end else if (fclk_p)
				n_fhigh <= n_fhigh + 1;
			// Every toggle is counted, so a surplus edge shows in the total
			if (bclk_p != bclk_q) begin
				if (n_edges < WORD_BITS)
					for (int c = 0; c < CH_COUNT; c++)
						rx_bits[c][n_edges[3:0]] <= data_p[c];
				n_edges <= n_edges + 1;
				if (n_edges == WORD_BITS - 1)
					n_frames <= n_frames + 1;
			end
		end
	end
endmodule : oals_rx_model

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_top import oals_pkg::*;;
	localparam time D = 1ns;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sample_clock_input = 1'b0;
	logic conv_valid = 1'b0;
	logic [SET_BITS-1:0] conv_data = '0;
	logic tcs = 1'b0;
	logic msbs = 1'b0;
	wire logic conv_ready;
	wire logic [CH_COUNT-1:0] dp;
	wire logic [CH_COUNT-1:0] dn;
	wire logic bp;
	wire logic bn;
	wire logic fp;
	wire logic fn;
	logic [WORD_BITS-1:0] rxb [CH_COUNT];
	int n_frames;
	int n_edges;
	int n_fhigh;
	logic pair_bad;
	int n_fail = 0;
	int compares = 0;

	always #2.5 ref_clk = ~ref_clk;

	oals_serializer DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.sample_clock_input(sample_clock_input), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .conv_data(conv_data),
		.twos_complement_select(tcs), .msb_first_select(msbs),
		.data_out_p(dp), .data_out_n(dn), .bit_clock_out_p(bp),
		.bit_clock_out_n(bn), .frame_clock_pos(fp), .frame_clock_neg(fn));
	oals_rx_model rx (.clk(ref_clk), .rst_n(rst_n), .data_p(dp), .data_n(dn),
		.bclk_p(bp), .bclk_n(bn), .fclk_p(fp), .fclk_n(fn),
		.rx_bits(rxb), .n_frames(n_frames),
		.n_edges(n_edges), .n_fhigh(n_fhigh), .pair_bad(pair_bad));

	////////////////////////////////////////////////////////////////////////
	task cmp_w(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_w

	task cmp_n(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_n

	function automatic logic [9:0] resv(int k, int c);
		if (k == 0)
			return 10'h000;
		if (k == 1)
			return 10'h3FF;
		return 10'(k * 8'h61 + c * 8'h1D + 8'h05);
	endfunction : resv

	task close_out;
		$display("Counts: %0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////
	// Fill while the link is still, so nothing drains meanwhile
	task t_fill;
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			cmp_w({11'h000, conv_ready}, 12'h001);
			for (int c = 0; c < CH_COUNT; c++)
				conv_data[c*RES_BITS +: RES_BITS] = resv(k, c);
			conv_valid = 1'b1;
			@(posedge ref_clk);
			#D;
		end
		cmp_w({11'h000, conv_ready}, 12'h000);
		repeat (4) @(posedge ref_clk);
		#D;
		conv_valid = 1'b0;
		$display("t_fill done");
	endtask : t_fill

	// One sample clock pulse of 32 ns, then it stands still until done
	task frame(input int k);
		int f0;
		logic [11:0] w;
		logic [11:0] e;
		f0 = n_frames;
		tcs = k[1];
		msbs = k[2];
		sample_clock_input = 1'b1;
		#32ns;
		sample_clock_input = 1'b0;
		for (int i = 0; i < 60 && n_frames == f0; i++)
			@(posedge ref_clk);
		#D;
		cmp_n(n_frames, f0 + 1);
		for (int c = 0; c < CH_COUNT; c++) begin
			w = {resv(k, c) ^ {k[1], 9'h000}, 2'b00};
			for (int i = 0; i < WORD_BITS; i++)
				e[i] = k[2] ? w[WORD_BITS-1-i] : w[i];
			cmp_w(rxb[c], e);
		end
		// Counted after the tail so a surplus clock edge is caught
		repeat (4) @(posedge ref_clk);
		#D;
		cmp_n(n_edges, WORD_BITS);
		cmp_n(n_fhigh, FRAME_TICKS / 2);
		cmp_w({3'h0, dp, fp}, 12'h000);
	endtask : frame

	task t_drain;
		for (int k = 0; k < FIFO_DEPTH; k++)
			frame(k);
		$display("t_drain done");
	endtask : t_drain

	// An edge with the buffer empty must not start a frame
	task t_idle;
		int f0;
		f0 = n_frames;
		cmp_w({11'h000, conv_ready}, 12'h001);
		sample_clock_input = 1'b1;
		#32ns;
		sample_clock_input = 1'b0;
		repeat (40) @(posedge ref_clk);
		#D;
		cmp_n(n_frames, f0);
		cmp_n(n_edges, WORD_BITS);
		cmp_w({3'h0, dp, fp}, 12'h000);
		cmp_w({11'h000, pair_bad}, 12'h000);
		$display("t_idle done");
	endtask : t_idle

	////////////////////////////////////////////////////////////////////////
	initial begin
		#20000ns;
		n_fail++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		#D;
		rst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#D;
		t_fill();
		t_drain();
		t_idle();
		close_out();
	end
endmodule : tb_top

`default_nettype wire
